// *** cebu_consts.svh ***
/*
 * constants for the condition and branch unit: field positions,
 * encodings, vectors and cycle costs.
 * assumes inclusion by bare name from the unit's sources.
 */
`ifndef CEBU_CONSTS_SVH
`define CEBU_CONSTS_SVH

`define CEBU_COND_HI        31
`define CEBU_COND_LO        28
`define CEBU_CLASS_HI       27
`define CEBU_CLASS_LO       25
`define CEBU_LINK_BIT       24
`define CEBU_OFFS_HI        23
`define CEBU_BRANCH_CLASS   3'h5
`define CEBU_PREFETCH_BYTES 32'h0000_0008
`define CEBU_WORD_BYTES     32'h0000_0004
`define CEBU_UNDEF_VECTOR   32'h0000_0004
`define CEBU_UNDEF_MODE     5'h1b
`define CEBU_RESET_VECTOR   32'h0000_0000
`define CEBU_BR_S_CYCLES    2'h2
`define CEBU_BR_N_CYCLES    2'h1
`define CEBU_IBIT_POS       7

`endif

// *** cebu_pkg.sv ***
/*
 * types shared by the condition and branch unit.
 * assumes nothing beyond a systemverilog compiler.
 */
package cebu_pkg;

	typedef enum logic [3:0] {
		CEBU_EQUAL_C = 4'h0, CEBU_NE_C = 4'h1, CEBU_CS_C = 4'h2,
		CEBU_CC_C = 4'h3, CEBU_MI_C = 4'h4, CEBU_PL_C = 4'h5,
		CEBU_VS_C = 4'h6, CEBU_VC_C = 4'h7, CEBU_HI_C = 4'h8,
		CEBU_LS_C = 4'h9, CEBU_GE_C = 4'ha, CEBU_LT_C = 4'hb,
		CEBU_GT_C = 4'hc, CEBU_LE_C = 4'hd,
		CEBU_ALWAYS_C = 4'he, CEBU_NEVER_C = 4'hf
	} cebu_cond_e;

	typedef enum logic [1:0] {
		CEBU_IDLE  = 2'b00,
		CEBU_SEQ   = 2'b01,
		CEBU_NSEQ  = 2'b10
	} cebu_state_e;

	typedef logic [31:0] cebu_word_t;

endpackage : cebu_pkg

// *** cebu_cond_if.sv ***
/*
 * interface carrying a condition query and its verdict between the
 * branch unit and its condition checker.
 * assumes one clock domain; purely combinational signals.
 */
`timescale 1ns/1ns
`default_nettype none

interface cebu_cond_if;
	logic [3:0] cond;
	logic [3:0] flags;
	logic       pass;
	logic       reserved;
	modport asker (output cond, output flags, input pass, input reserved);
	modport judge (input cond, input flags, output pass, output reserved);
endinterface : cebu_cond_if

`default_nettype wire

// *** cebu_cond_check.sv ***
/*
 * condition evaluator: decides from the four status flags whether an
 * instruction with the given condition field may take effect.
 * assumes flags ordered negative, zero, carry, overflow from bit 3.
 */
`timescale 1ns/1ns
`default_nettype none

module cebu_cond_check
	import cebu_pkg::*;
(
	cebu_cond_if.judge c
);
	wire n = c.flags[3];
	wire z = c.flags[2];
	wire cy = c.flags[1];
	wire v = c.flags[0];
	wire [15:0] truth;

	assign truth[CEBU_EQUAL_C]  = z;
	assign truth[CEBU_NE_C]     = ~z;
	assign truth[CEBU_CS_C]     = cy;
	assign truth[CEBU_CC_C]     = ~cy;
	assign truth[CEBU_MI_C]     = n;
	assign truth[CEBU_PL_C]     = ~n;
	assign truth[CEBU_VS_C]     = v;
	assign truth[CEBU_VC_C]     = ~v;
	assign truth[CEBU_HI_C]     = cy & ~z;
	assign truth[CEBU_LS_C]     = ~cy | z;
	assign truth[CEBU_GE_C]     = n == v;
	assign truth[CEBU_LT_C]     = n != v;
	assign truth[CEBU_GT_C]     = ~z & (n == v);
	assign truth[CEBU_LE_C]     = z | (n != v);
	assign truth[CEBU_ALWAYS_C] = 1'b1;
	// reserved class never executes, and is flagged for the source
	assign truth[CEBU_NEVER_C]  = 1'b0;

	assign c.pass     = truth[c.cond];
	assign c.reserved = c.cond == CEBU_NEVER_C;
endmodule : cebu_cond_check

`default_nettype wire

// *** cebu_unit.sv ***
/*
 * condition gate and branch executor of the core's instruction stage.
 * assumes the fetch path presents one instruction with its address and
 * a valid strobe, and holds it while ready is low.
 */
// Functional notes
// - condition field gates every instruction against flags
// - always condition executes regardless of flags
// - equal condition needs zero flag set
// - offset shifted two, sign-extended, added to pc
// - pc base is instruction address plus eight
// - link form writes next address, status untouched
// - plain branch leaves link register alone
// - branch costs two sequential, one nonsequential cycle
// - unhandled instruction enters undefined mode, vector 0x04
`timescale 1ns/1ns
`default_nettype none
`include "cebu_consts.svh"

module cebu_unit
	import cebu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr,
	input  wire logic [31:0] instr_addr,
	input  wire logic [3:0]  flags,
	input  wire logic        other_handled,
	input  wire logic        coproc_accept,
	output logic             instr_ready,
	output logic             fetch_redirect,
	output logic [31:0]      fetch_addr,
	output logic             link_we,
	output logic [31:0]      link_data,
	output logic             mode_we,
	output logic [4:0]       mode_value,
	output logic             irq_disable_set,
	output logic             skipped,
	output logic             cycle_seq,
	output logic             cycle_nseq,
	output logic             reserved_cond
);

	////////////////////////////////////////////////////////////////////
	// decode

	cebu_cond_if cif ();
	assign cif.cond  = instr[`CEBU_COND_HI:`CEBU_COND_LO];
	assign cif.flags = flags;

	cebu_cond_check u_cond (
		.c (cif)
	);

	cebu_state_e state_reg;
	cebu_state_e state_next;
	logic [1:0]  cnt_reg;
	logic [1:0]  cnt_next;

	wire idle      = state_reg == CEBU_IDLE;
	wire take      = instr_valid & idle;
	wire is_branch = instr[`CEBU_CLASS_HI:`CEBU_CLASS_LO]
	                 == `CEBU_BRANCH_CLASS;
	wire is_link   = instr[`CEBU_LINK_BIT];
	wire passes    = cif.pass;
	// undefined only when nobody, coprocessor included, claims it
	wire is_undef  = ~is_branch & ~other_handled & ~coproc_accept;

	wire [31:0] offs_ext = {{6{instr[`CEBU_OFFS_HI]}},
	                        instr[`CEBU_OFFS_HI:0], 2'b00};
	wire [31:0] pc_base  = instr_addr + `CEBU_PREFETCH_BYTES;
	wire [31:0] target   = pc_base + offs_ext;
	wire [31:0] next_adr = instr_addr + `CEBU_WORD_BYTES;

	wire do_branch = take & passes & is_branch;
	wire do_undef  = take & passes & is_undef;
	wire do_skip   = take & ~passes;

	////////////////////////////////////////////////////////////////////
	// branch cycle sequencer: one nonsequential then two sequential

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			CEBU_IDLE: begin
				if (do_branch) begin
					state_next = CEBU_NSEQ;
				end
			end
			CEBU_NSEQ: begin
				state_next = CEBU_SEQ;
				cnt_next   = `CEBU_BR_S_CYCLES - 2'h1;
			end
			CEBU_SEQ: begin
				if (cnt_reg == 2'h0) begin
					state_next = CEBU_IDLE;
				end else begin
					cnt_next = cnt_reg - 2'h1;
				end
			end
			default: begin
				state_next = CEBU_IDLE;
			end
		endcase
	end

	// the take cycle is issue, not cost: N then two S follow it, and
	// ready stays low across all three so nothing slips in mid-refill
	assign instr_ready = idle;
	assign cycle_nseq  = state_reg == CEBU_NSEQ;
	assign cycle_seq   = state_reg == CEBU_SEQ;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= CEBU_IDLE;
			cnt_reg   <= 2'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// next values of the registered effects

	// branch and trap are exclusive: a trap needs a non-branch word
	wire [31:0] fetch_addr_next = do_branch ? target :
	                              do_undef  ? `CEBU_UNDEF_VECTOR :
	                              take      ? next_adr :
	                              fetch_addr;
	// a plain branch never raises the write strobe
	wire        link_fire       = do_branch & is_link;
	wire [31:0] link_data_next  = link_fire ? next_adr : link_data;
	wire [4:0]  mode_value_next = do_undef ? `CEBU_UNDEF_MODE : 5'h00;

	////////////////////////////////////////////////////////////////////
	// registered effects, one short block per group

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fetch_redirect <= 1'b0;
			fetch_addr     <= `CEBU_RESET_VECTOR;
		end else begin
			fetch_redirect <= do_branch | do_undef;
			fetch_addr     <= fetch_addr_next;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			link_we   <= 1'b0;
			link_data <= 32'h0000_0000;
		end else begin
			link_we   <= link_fire;
			link_data <= link_data_next;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_we         <= 1'b0;
			mode_value      <= 5'h00;
			irq_disable_set <= 1'b0;
		end else begin
			mode_we         <= do_undef;
			mode_value      <= mode_value_next;
			irq_disable_set <= do_undef;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			skipped       <= 1'b0;
			reserved_cond <= 1'b0;
		end else begin
			skipped       <= do_skip;
			reserved_cond <= take & cif.reserved;
		end
	end

endmodule : cebu_unit

`default_nettype wire

// *** cebu_props.sv ***
/* checker for the condition and branch unit, bound to its top module.
   assumes one clock domain and registered answers one edge after take. */
`timescale 1ns/1ns
`default_nettype none
module cebu_props (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        instr_valid,
	input wire logic [31:0] instr,
	input wire logic [31:0] instr_addr,
	input wire logic [3:0]  flags,
	input wire logic        instr_ready,
	input wire logic        fetch_redirect,
	input wire logic [31:0] fetch_addr,
	input wire logic        link_we,
	input wire logic [31:0] link_data,
	input wire logic        mode_we,
	input wire logic [4:0]  mode_value,
	input wire logic        irq_disable_set,
	input wire logic        skipped,
	input wire logic        cycle_seq,
	input wire logic        cycle_nseq,
	input wire logic        other_handled,
	input wire logic        coproc_accept,
	input wire logic        reserved_cond
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire        take      = instr_valid & instr_ready;
	wire        br_always = take && instr[31:25] == 7'h75;
	wire        non_br    = instr[27:25] != 3'h5;
	wire [31:0] offs      = {{6{instr[23]}}, instr[23:0], 2'b00};
	a_branch_target: assert property (
		br_always |=> fetch_redirect &&
		fetch_addr == $past(instr_addr) + 32'h8 + $past(offs))
		else $error("branch target wrong");
	a_link_write: assert property (
		br_always && instr[24] |=> link_we &&
		link_data == $past(instr_addr) + 32'h4)
		else $error("link write wrong");
	a_plain_nolink: assert property (
		take && instr[27:25] == 3'h5 && !instr[24] |=> !link_we)
		else $error("plain branch wrote link");
	a_branch_busy: assert property (
		br_always |=> !instr_ready [*3] ##1 instr_ready)
		else $error("branch busy window wrong");
	a_cycle_kinds: assert property (
		br_always |-> (!cycle_seq && !cycle_nseq) ##1
		(cycle_nseq && !cycle_seq) ##1 (cycle_seq && !cycle_nseq) [*2]
		##1 (!cycle_seq && !cycle_nseq))
		else $error("branch cycle kinds wrong");
	a_equal_skip: assert property (
		take && instr[31:28] == 4'h0 && !flags[2] |=>
		skipped && !fetch_redirect)
		else $error("equal condition not skipped");
	a_always_runs: assert property (
		take && instr[31:28] == 4'he |=> !skipped)
		else $error("always condition skipped");
	a_skip_quiet: assert property (
		skipped |-> fetch_addr == $past(instr_addr) + 32'h4 &&
		!link_we && !mode_we)
		else $error("skipped instruction had effect");
	a_undef_entry: assert property (
		mode_we |-> mode_value == 5'h1b && irq_disable_set &&
		fetch_redirect && fetch_addr == 32'h4)
		else $error("undefined entry wrong");
	a_undef_fires: assert property (
		take && instr[31:28] == 4'he && non_br && !other_handled &&
		!coproc_accept |=> mode_we)
		else $error("undefined entry missing");
	a_claimed_quiet: assert property (
		take && non_br && (other_handled || coproc_accept) |=>
		!mode_we && !fetch_redirect)
		else $error("claimed instruction trapped");
	a_reserved_quiet: assert property (
		take && instr[31:28] != 4'hf |=> !reserved_cond)
		else $error("reserved flag without never condition");
endmodule : cebu_props
bind cebu_unit cebu_props u_props (.clk, .arst_n, .instr_valid, .instr,
	.instr_addr, .flags, .instr_ready, .fetch_redirect, .fetch_addr,
	.link_we, .link_data, .mode_we, .mode_value, .irq_disable_set,
	.skipped, .cycle_seq, .cycle_nseq, .other_handled, .coproc_accept,
	.reserved_cond);
`default_nettype wire

// *** cebu_fetch_model.sv ***
/* fetch path model: offers one word with its address, held until taken.
   assumes issue is called from one thread at a time. */
`timescale 1ns/1ns
`default_nettype none
module cebu_fetch_model (
	input  wire logic        clk,
	input  wire logic        instr_ready,
	output logic             instr_valid,
	output logic [31:0]      instr,
	output logic [31:0]      instr_addr
);
	initial begin
		instr_valid = 1'b0;
		instr = 32'h0;
		instr_addr = 32'h0;
	end
	// callers offer no never-condition words; the one untrapped undefined word fails its condition
	task automatic issue(input logic [31:0] w, input logic [31:0] a);
		@(negedge clk);
		instr_valid = 1'b1;
		instr = w;
		instr_addr = a;
		while (instr_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		@(negedge clk);
		instr_valid = 1'b0;
		// released bus shows a changed value so stale data cannot pass
		instr = ~w;
		instr_addr = ~a;
	endtask : issue
endmodule : cebu_fetch_model
`default_nettype wire

// *** cebu_tb.sv ***
/* self-checking bench for the condition and branch unit.
   assumes the fetch model drives the instruction side. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import cebu_pkg::*;
	logic        clk = 1'b0, arst_n = 1'b0;
	logic [3:0]  flags = 4'h0;
	logic        other_handled = 1'b1, coproc_accept = 1'b0;
	logic        instr_valid, instr_ready, fetch_redirect, link_we;
	logic        mode_we, irq_disable_set, skipped, cycle_seq;
	logic        cycle_nseq, reserved_cond;
	logic [31:0] instr, instr_addr, fetch_addr, link_data;
	logic [4:0]  mode_value;
	int          checks_done = 0, miscompares = 0, cycles = 0;
	always #25 clk = ~clk;
	cebu_fetch_model fm (.clk, .instr_ready, .instr_valid, .instr,
		.instr_addr);
	cebu_unit dut (.clk, .arst_n, .instr_valid, .instr, .instr_addr, .flags,
		.other_handled, .coproc_accept, .instr_ready, .fetch_redirect,
		.fetch_addr, .link_we, .link_data, .mode_we, .mode_value,
		.irq_disable_set, .skipped, .cycle_seq, .cycle_nseq, .reserved_cond);
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_w
	task automatic chk_b(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_b
	function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
		logic r;
		case (c[3:1])
			3'h0: r = f[2];
			3'h1: r = f[1];
			3'h2: r = f[3];
			3'h3: r = f[0];
			3'h4: r = f[1] & ~f[2];
			3'h5: r = f[3] == f[0];
			3'h6: r = ~f[2] & (f[3] == f[0]);
			default: r = 1'b1;
		endcase
		return c[0] && c != 4'hf ? ~r : r;
	endfunction : cond_ok
	task automatic t_cond;
		for (int c = 0; c < 15; c++) begin
			for (int f = 0; f < 16; f++) begin
				flags = 4'(f);
				fm.issue({4'(c), 28'h0}, 32'h1000);
				chk_b(skipped, ~cond_ok(4'(c), 4'(f)));
				chk_b(fetch_redirect, 1'b0);
				chk_w(fetch_addr, 32'h1004);
				chk_b(reserved_cond, 1'b0);
			end
		end
	endtask : t_cond
	task automatic br(input logic [31:0] w, a, tgt, input logic lk);
		fm.issue(w, a);
		chk_b(fetch_redirect, 1'b1);
		chk_w(fetch_addr, tgt);
		chk_b(link_we, lk);
		if (lk)
			chk_w(link_data, a + 32'h4);
		chk_b(cycle_nseq & ~instr_ready, 1'b1);
		repeat (2) begin
			@(negedge clk);
			chk_b(cycle_seq & ~instr_ready, 1'b1);
		end
		@(negedge clk);
		chk_b(instr_ready, 1'b1);
	endtask : br
	task automatic t_branch;
		br(32'heb00_0010, 32'h100, 32'h148, 1'b1);
		br(32'heaff_fffe, 32'h2000, 32'h2000, 1'b0);
		flags = 4'h4;
		br(32'h0a00_0003, 32'h500, 32'h514, 1'b0);
		flags = 4'h0;
		fm.issue(32'h0b00_0001, 32'h400);
		chk_b(skipped, 1'b1);
		chk_b(link_we | fetch_redirect, 1'b0);
		chk_w(fetch_addr, 32'h404);
	endtask : t_branch
	task automatic t_undef;
		other_handled = 1'b0;
		fm.issue(32'he000_0000, 32'h300);
		chk_b(mode_we & irq_disable_set & fetch_redirect, 1'b1);
		chk_w({27'h0, mode_value}, 32'h1b);
		chk_w(fetch_addr, 32'h4);
		coproc_accept = 1'b1;
		fm.issue(32'he000_0000, 32'h304);
		chk_b(mode_we, 1'b0);
		coproc_accept = 1'b0;
		fm.issue(32'h0000_0000, 32'h308);
		chk_b(mode_we | ~skipped, 1'b0);
	endtask : t_undef
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		repeat (20) @(negedge clk);
		arst_n = 1'b1;
		t_cond();
		t_branch();
		t_undef();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
